/* File: rtl/lcg_params.svh */
// Register offsets, field positions and reset values of the gate-4 select block
`ifndef LCG_PARAMS_SVH
`define LCG_PARAMS_SVH

// Byte addresses on the APB bus
`define LCG_OFS_SEL_CELL1   12'h000
`define LCG_OFS_SEL_CELL2   12'h004
`define LCG_OFS_MIRROR      12'h008

// Field positions in gate4_input_select
`define LCG_G4_IN4_TRUE     7
`define LCG_G4_IN4_NEG      6
`define LCG_G4_IN3_TRUE     5
`define LCG_G4_IN3_NEG      4
`define LCG_G4_IN2_TRUE     3
`define LCG_G4_IN2_NEG      2
`define LCG_G4_IN1_TRUE     1
`define LCG_G4_IN1_NEG      0

// Field positions in cell_output_mirror
`define LCG_CELL2_OUT_MIRROR 1
`define LCG_CELL1_OUT_MIRROR 0

// Reset values
`define LCG_SEL_RESET       8'h00
`define LCG_MIRROR_RESET    8'h00

`endif

/* File: rtl/lcg_pkg.sv */
// Types and address decode shared by the gate-4 select block
`include "lcg_params.svh"
package lcg_pkg;
    typedef logic [7:0]  lcg_byte_t;
    typedef logic [11:0] lcg_addr_t;
    typedef enum logic [1:0] {LCG_REG_SEL1, LCG_REG_SEL2, LCG_REG_MIRROR, LCG_REG_NONE} lcg_reg_t;

    // Word-aligned decode; any other address is unmapped
    function automatic lcg_reg_t lcg_decode(input lcg_addr_t addr);
        lcg_reg_t r;
        r = LCG_REG_NONE;
        if (addr == `LCG_OFS_SEL_CELL1) r = LCG_REG_SEL1;
        if (addr == `LCG_OFS_SEL_CELL2) r = LCG_REG_SEL2;
        if (addr == `LCG_OFS_MIRROR)    r = LCG_REG_MIRROR;
        return r;
    endfunction : lcg_decode
endpackage : lcg_pkg

/* File: rtl/lcg_reg_if.sv */
// Register access signals between the APB slave and the register file
`timescale 1ns/1ns
interface lcg_reg_if;
    lcg_pkg::lcg_addr_t addr;
    logic [31:0]        wdata;
    logic               wr;
    logic [31:0]        rdata;
    logic               err;

    modport slave (output addr, output wdata, output wr, input rdata, input err);
    modport regs  (input addr, input wdata, input wr, output rdata, output err);
endinterface : lcg_reg_if

/* File: rtl/lcg_gate4.sv */
// Gate-4 data gating for one logic cell, registered output
`timescale 1ns/1ns
`include "lcg_params.svh"
module lcg_gate4 (
    input  wire logic           clk,
    input  wire logic           rst,
    input  wire logic [3:0]     data_in,
    input  lcg_pkg::lcg_byte_t  sel,
    output logic                gate4_out
);
    logic next_gate4_out;

    // OR of every selected true or negated data form
    always_comb begin
        next_gate4_out = 1'b0;
        next_gate4_out |= sel[`LCG_G4_IN4_TRUE] & data_in[3];
        next_gate4_out |= sel[`LCG_G4_IN4_NEG] & ~data_in[3];
        next_gate4_out |= sel[`LCG_G4_IN3_TRUE] & data_in[2];
        next_gate4_out |= sel[`LCG_G4_IN3_NEG] & ~data_in[2];
        next_gate4_out |= sel[`LCG_G4_IN2_TRUE] & data_in[1];
        next_gate4_out |= sel[`LCG_G4_IN2_NEG] & ~data_in[1];
        next_gate4_out |= sel[`LCG_G4_IN1_TRUE] & data_in[0];
        next_gate4_out |= sel[`LCG_G4_IN1_NEG] & ~data_in[0];
    end

    // Registered so the top output comes from a flop
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            gate4_out <= 1'b0;
        end else begin
            gate4_out <= next_gate4_out;
        end
    end
endmodule : lcg_gate4

/* File: rtl/lcg_apb_slave.sv */
// APB slave: no wait state, registered answer
`timescale 1ns/1ns
module lcg_apb_slave (
    input  wire logic         clk,
    input  wire logic         rst,
    input  wire logic         psel,
    input  wire logic         penable,
    input  wire logic         pwrite,
    input  wire logic [11:0]  paddr,
    input  wire logic [31:0]  pwdata,
    output logic              pready,
    output logic [31:0]       prdata,
    output logic              pslverr,
    lcg_reg_if.slave          bus
);
    logic setup;

    // Setup phase seen only once per transfer
    assign setup     = psel & ~penable;
    assign bus.addr  = paddr;
    assign bus.wdata = pwdata;
    // Write lands on the edge that completes the access
    assign bus.wr    = psel & penable & pwrite & pready;

    // Answer prepared in setup so every output is a flop
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            pready  <= 1'b0;
            prdata  <= 32'h0000_0000;
            pslverr <= 1'b0;
        end else if (setup) begin
            pready  <= 1'b1;
            prdata  <= pwrite ? 32'h0000_0000 : bus.rdata;
            pslverr <= bus.err;
        end else begin
            pready  <= 1'b0;
            prdata  <= 32'h0000_0000;
            pslverr <= 1'b0;
        end
    end
endmodule : lcg_apb_slave

/* File: rtl/lcg_top.sv */
// Gate-4 input selection for two logic cells and the cell output mirror register
//
// How it works
// - Data 4 select bits gate true/negated form
// - Data 3 select bits gate true/negated form
// - Data 2 select bits gate true/negated form
// - Data 1 select bits gate true/negated form
// - Gate-4 select register is software read/write
// - Mirror bit 1 follows cell 2 output
// - Mirror bit 0 follows cell 1 output
// - Mirror bits 7..2 always read zero
//
// Implementation choices: the placing of the registers and the APB register port.
`timescale 1ns/1ns
`include "lcg_params.svh"
module lcg_top (
    input  wire logic         CLK,
    input  wire logic         RST,
    input  wire logic         PSEL,
    input  wire logic         PENABLE,
    input  wire logic         PWRITE,
    input  wire logic [11:0]  PADDR,
    input  wire logic [31:0]  PWDATA,
    output logic              PREADY,
    output logic [31:0]       PRDATA,
    output logic              PSLVERR,
    input  wire logic [3:0]   CELL1_DATA,
    input  wire logic [3:0]   CELL2_DATA,
    input  wire logic         CELL1_OUTPUT,
    input  wire logic         CELL2_OUTPUT,
    output logic [1:0]        GATE4_OUT
);
    lcg_reg_if                bus ();
    lcg_pkg::lcg_byte_t       gate4_input_select [2];
    lcg_pkg::lcg_byte_t       cell_output_mirror;
    lcg_pkg::lcg_reg_t        wr_reg;
    lcg_pkg::lcg_reg_t        rd_reg;
    logic [3:0]               cell_data [2];

    assign cell_data[0] = CELL1_DATA;
    assign cell_data[1] = CELL2_DATA;

    lcg_apb_slave u_apb (
        .clk     (CLK),
        .rst     (RST),
        .psel    (PSEL),
        .penable (PENABLE),
        .pwrite  (PWRITE),
        .paddr   (PADDR),
        .pwdata  (PWDATA),
        .pready  (PREADY),
        .prdata  (PRDATA),
        .pslverr (PSLVERR),
        .bus     (bus.slave)
    );

    assign wr_reg = lcg_pkg::lcg_decode(bus.addr);
    assign rd_reg = lcg_pkg::lcg_decode(bus.addr);

    // Select registers; reset to a known value rather than left undefined
    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            gate4_input_select[0] <= `LCG_SEL_RESET;
            gate4_input_select[1] <= `LCG_SEL_RESET;
        end else if (bus.wr) begin
            if (wr_reg == lcg_pkg::LCG_REG_SEL1) begin
                gate4_input_select[0] <= bus.wdata[7:0];
            end
            if (wr_reg == lcg_pkg::LCG_REG_SEL2) begin
                gate4_input_select[1] <= bus.wdata[7:0];
            end
        end
    end

    // Mirror sampled every clock; bus writes never reach it
    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            cell_output_mirror <= `LCG_MIRROR_RESET;
        end else begin
            cell_output_mirror <= `LCG_MIRROR_RESET;
            cell_output_mirror[`LCG_CELL2_OUT_MIRROR] <= CELL2_OUTPUT;
            cell_output_mirror[`LCG_CELL1_OUT_MIRROR] <= CELL1_OUTPUT;
        end
    end

    // Read mux; upper bits of every word read zero
    always_comb begin
        bus.rdata = 32'h0000_0000;
        bus.err   = 1'b0;
        unique case (rd_reg)
            lcg_pkg::LCG_REG_SEL1:   bus.rdata[7:0] = gate4_input_select[0];
            lcg_pkg::LCG_REG_SEL2:   bus.rdata[7:0] = gate4_input_select[1];
            lcg_pkg::LCG_REG_MIRROR: bus.rdata[7:0] = cell_output_mirror;
            lcg_pkg::LCG_REG_NONE:   bus.err        = 1'b1;
        endcase
    end

    // One gate-4 stage per cell
    for (genvar c = 0; c < 2; c++) begin : g_cell
        lcg_gate4 u_gate4 (
            .clk       (CLK),
            .rst       (RST),
            .data_in   (cell_data[c]),
            .sel       (gate4_input_select[c]),
            .gate4_out (GATE4_OUT[c])
        );
    end
endmodule : lcg_top

/* File: tb/lcg_cell_model.sv */
// Behavioural upstream stage: data selector outputs and logic cell outputs
`timescale 1ns/1ns
module lcg_cell_model (
    input  wire logic       clk,
    input  wire logic       rst,
    input  wire logic [9:0] pat,
    output logic [3:0]      d1,
    output logic [3:0]      d2,
    output logic            o1,
    output logic            o2
);
    // Registered like the real stage, so every change lands one edge late
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            {o2, o1, d2, d1} <= 10'h000;
        end else begin
            {o2, o1, d2, d1} <= pat;
        end
    end
endmodule : lcg_cell_model

/* File: tb/lcg_assertions.sv */
// Port-level checks for the gate-4 select block
`timescale 1ns/1ns
module lcg_assertions (
    input wire logic        CLK,
    input wire logic        RST,
    input wire logic        PSEL,
    input wire logic        PENABLE,
    input wire logic        PWRITE,
    input wire logic [11:0] PADDR,
    input wire logic [31:0] PWDATA,
    input wire logic        PREADY,
    input wire logic [31:0] PRDATA,
    input wire logic        PSLVERR,
    input wire logic [3:0]  CELL1_DATA,
    input wire logic [3:0]  CELL2_DATA,
    input wire logic        CELL1_OUTPUT,
    input wire logic        CELL2_OUTPUT,
    input wire logic [1:0]  GATE4_OUT
);
    logic [7:0] s1;
    logic [7:0] s2;
    wire        wr = PSEL && PENABLE && PREADY && PWRITE;
    wire        rd = PREADY && !PWRITE;
    // Gate 4 is the OR of the selected true and negated data forms
    function automatic logic g(input logic [7:0] s, input logic [3:0] d);
        return |(s & {d[3], ~d[3], d[2], ~d[2], d[1], ~d[1], d[0], ~d[0]});
    endfunction : g
    // Shadow select registers; only completed writes move them
    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            s1 <= 8'h00;
            s2 <= 8'h00;
        end else if (wr && PADDR == 12'h000) begin
            s1 <= PWDATA[7:0];
        end else if (wr && PADDR == 12'h004) begin
            s2 <= PWDATA[7:0];
        end
    end
    default clocking cb @(posedge CLK); endclocking
    default disable iff (RST);
    gate_cell1_a: assert property (GATE4_OUT[0] == g($past(s1), $past(CELL1_DATA)))
        else $error("cell 1 gate 4 wrong");
    gate_cell2_a: assert property (GATE4_OUT[1] == g($past(s2), $past(CELL2_DATA)))
        else $error("cell 2 gate 4 wrong");
    sel_read_a: assert property (rd && PADDR[11:3] == 9'h000 && PADDR[1:0] == 2'h0
        |-> PRDATA == {24'h0, PADDR[2] ? s2 : s1}) else $error("select readback wrong");
    mirror_hi_a: assert property (rd && PADDR == 12'h008 |-> PRDATA[1] == $past(CELL2_OUTPUT, 2))
        else $error("mirror bit 1 wrong");
    mirror_lo_a: assert property (rd && PADDR == 12'h008 |-> PRDATA[0] == $past(CELL1_OUTPUT, 2))
        else $error("mirror bit 0 wrong");
    mirror_zero_a: assert property (rd && PADDR == 12'h008 |-> PRDATA[31:2] == 30'h0)
        else $error("mirror upper bits set");
    mirror_write_a: assert property (PREADY && PWRITE && PADDR == 12'h008 |-> !PSLVERR)
        else $error("mirror write flagged");
    unmapped_err_a: assert property (PREADY && PADDR > 12'h008 |-> PSLVERR && PRDATA == 32'h0)
        else $error("unmapped access not refused");
endmodule : lcg_assertions

bind lcg_top lcg_assertions chk (.CLK(CLK), .RST(RST), .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE),
    .PADDR(PADDR), .PWDATA(PWDATA), .PREADY(PREADY), .PRDATA(PRDATA), .PSLVERR(PSLVERR),
    .CELL1_DATA(CELL1_DATA), .CELL2_DATA(CELL2_DATA), .CELL1_OUTPUT(CELL1_OUTPUT),
    .CELL2_OUTPUT(CELL2_OUTPUT), .GATE4_OUT(GATE4_OUT));

/* File: tb/tb_top.sv */
// Self-checking bench for the gate-4 select block
`timescale 1ns/1ns
module tb_top;
    logic        clk = 1'b0, rst = 1'b1, psel = 1'b0, pen = 1'b0, pwr = 1'b0;
    logic [11:0] pa = 12'h000;
    logic [31:0] pwd = 32'h0, prd, rd;
    logic [9:0]  pat = 10'h000;
    logic [3:0]  d1, d2;
    logic [1:0]  g4;
    logic        rdy, err, er, o1, o2;
    int          n_fail = 0, checks = 0;
    always #5 clk = ~clk;
    lcg_cell_model pm (.clk(clk), .rst(rst), .pat(pat), .d1(d1), .d2(d2), .o1(o1), .o2(o2));
    lcg_top uut (.CLK(clk), .RST(rst), .PSEL(psel), .PENABLE(pen), .PWRITE(pwr), .PADDR(pa), .PWDATA(pwd),
        .PREADY(rdy), .PRDATA(prd), .PSLVERR(err), .CELL1_DATA(d1), .CELL2_DATA(d2), .CELL1_OUTPUT(o1),
        .CELL2_OUTPUT(o2), .GATE4_OUT(g4));
    task print_verdict;
        $display("mismatches %0d of %0d checks", n_fail, checks);
        if (n_fail == 0 && checks > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask : print_verdict
    task chk(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp) begin
            n_fail++;
            $display("unexpected at %0t: got %h want %h", $time, got, exp);
        end
    endtask : chk
    // One APB transfer; answer taken at the rising edge that sees PREADY, released only after it
    task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clk);
        {psel, pen, pwr, pa, pwd} <= {2'b10, w, a, d};
        @(posedge clk);
        pen <= 1'b1;
        do begin
            @(posedge clk);
            n++;
        end while (rdy !== 1'b1 && n < 16);
        {rd, er} = {prd, err};
        {psel, pen} <= 2'b00;
        chk({31'h0, rdy}, 32'h1);
        if (rdy !== 1'b1) print_verdict();
    endtask : apb
    // Reset values, read-back, refused and ignored writes
    task t_regs;
        for (int i = 0; i < 3; i++) begin
            apb(1'b0, 12'(4 * i), 32'h0);
            chk(rd, 32'h0);
        end
        apb(1'b1, 12'h000, 32'h000000A5);
        apb(1'b1, 12'h004, 32'h0000005A);
        apb(1'b1, 12'h00C, 32'h000000FF);
        chk({31'h0, er}, 32'h1);
        apb(1'b1, 12'h008, 32'h000000FF);
        chk({31'h0, er}, 32'h0);
        apb(1'b0, 12'h000, 32'h0);
        chk(rd, 32'h000000A5);
        apb(1'b0, 12'h004, 32'h0);
        chk(rd, 32'h0000005A);
        apb(1'b0, 12'h008, 32'h0);
        chk(rd, 32'h0);
    endtask : t_regs
    // Each select bit alone; the two cells see complementary data
    task t_gate;
        int e;
        pat <= 10'h0A5;
        for (int i = 0; i < 8; i++) begin
            apb(1'b1, 12'h000, 32'(1 << i));
            apb(1'b1, 12'h004, 32'(1 << i));
            repeat (3) @(negedge clk);
            e = ((5 >> (i >> 1)) ^ (i + 1)) & 1;
            chk({30'h0, g4}, {30'h0, ~e[0], e[0]});
        end
        // Both forms of one input selected: always passes; nothing selected: never passes
        apb(1'b1, 12'h000, 32'h000000C0);
        apb(1'b1, 12'h004, 32'h00000000);
        repeat (3) @(negedge clk);
        chk({30'h0, g4}, 32'h00000001);
    endtask : t_gate
    // Every cell output pair shows in the two low mirror bits only
    task t_mirror;
        for (int i = 0; i < 4; i++) begin
            @(posedge clk);
            pat <= 10'(i << 8);
            repeat (3) @(posedge clk);
            apb(1'b0, 12'h008, 32'h0);
            chk(rd, 32'(i));
        end
    endtask : t_mirror
    initial begin
        repeat (8) @(posedge clk);
        rst <= 1'b0;
        t_regs();
        t_gate();
        t_mirror();
        print_verdict();
    end
endmodule : tb_top
